// >>> rtl/timer_counter_pwm_16bit.sv
// 16-bit down-counting timer, counter and pwm unit with capture and deadband
// assumes configuration and control inputs come from logic on ref_clk_i;
// clk_src_i are foreign and are synchronised here
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - sixteen-bit counter counts down once per selected clock tick while allowed
// - compare true uses less, less-equal, equal, greater-equal or greater relation
// - period reloads on start, on reset input, and at terminal count
// - interrupt raised on terminal count, compare true or capture, each selectable
// - one-shot mode runs one period then halts
// - gated mode advances only while enable input is high
// - free-run mode counts and reloads forever
// - kill input forces both pwm outputs inactive
// - capture input latches the full counter into a readable register
// - drives compare, complementary compare, terminal count and interrupt outputs
// - complementary pwm pair separated by deadband, never both active
// - counting clock chosen among system clock and three sources
module timer_counter_pwm_16bit (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [1:0] clk_sel_i,
  input wire logic [tcpwm_pkg::SRC_N-1:0] clk_src_i,
  input wire logic start_i,
  input wire logic [1:0] mode_i,
  input wire logic [2:0] cmp_rel_i,
  input wire logic [tcpwm_pkg::CNT_W-1:0] period_i,
  input wire logic [tcpwm_pkg::CNT_W-1:0] compare_i,
  input wire logic [tcpwm_pkg::DB_W-1:0] dead_len_i,
  input wire logic [2:0] irq_sel_i,
  input wire logic enable_i,
  input wire logic timer_reset_i,
  input wire logic capture_i,
  input wire logic kill_i,
  output logic [tcpwm_pkg::CNT_W-1:0] count_o,
  output logic [tcpwm_pkg::CNT_W-1:0] capture_o,
  output logic running_o,
  output logic compare_o,
  output logic compare_n_o,
  output logic tc_o,
  output logic irq_o
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic cmp_true(input logic [2:0] rel,
                                    input logic [tcpwm_pkg::CNT_W-1:0] cnt,
                                    input logic [tcpwm_pkg::CNT_W-1:0] cmp);
    logic r;
    r = 1'b0;
    case (rel)
      tcpwm_pkg::less_than: r = cnt < cmp;
      tcpwm_pkg::less_or_equal: r = cnt <= cmp;
      tcpwm_pkg::same_value: r = cnt == cmp;
      tcpwm_pkg::greater_or_equal: r = cnt >= cmp;
      tcpwm_pkg::greater_than: r = cnt > cmp;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  logic [tcpwm_pkg::SRC_N-1:0] src_s1_r;
  logic [tcpwm_pkg::SRC_N-1:0] src_s2_r;
  logic [tcpwm_pkg::SRC_N-1:0] src_s3_r;
  logic [tcpwm_pkg::SRC_N-1:0] src_rise;
  logic tick;
  logic advance;
  logic at_zero;
  logic start_d_r;
  logic start_rise;
  logic cap_d_r;
  logic cap_rise;
  logic cmp_now;
  logic cmp_d_r;
  tcpwm_pkg::run_state_t state_r;
  logic [tcpwm_pkg::CNT_W-1:0] count_r;
  logic [tcpwm_pkg::CNT_W-1:0] capture_r;
  logic tc_r;
  logic irq_r;
  pwm_if pw ();

  // ----------------------------------------
  // counting clock selection
  // ----------------------------------------
  // third stage only feeds edge detect, so the first stage stays clean
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      src_s1_r <= tcpwm_pkg::SRC_RST;
      src_s2_r <= tcpwm_pkg::SRC_RST;
      src_s3_r <= tcpwm_pkg::SRC_RST;
    end else begin
      src_s1_r <= clk_src_i;
      src_s2_r <= src_s1_r;
      src_s3_r <= src_s2_r;
    end
  end

  assign src_rise = src_s2_r & ~src_s3_r;

  always_comb begin
    if (clk_sel_i == tcpwm_pkg::CLKSEL_SYS) begin
      tick = 1'b1;
    end else begin
      tick = src_rise[clk_sel_i - 2'h1];
    end
  end

  // ----------------------------------------
  // run control
  // ----------------------------------------
  assign start_rise = start_i && !start_d_r;
  assign at_zero = count_r == tcpwm_pkg::CNT_ZERO;
  assign advance = state_r == tcpwm_pkg::ST_RUN && tick &&
                   (mode_i != tcpwm_pkg::MODE_GATED || enable_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      start_d_r <= 1'b0;
    end else begin
      start_d_r <= start_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      state_r <= tcpwm_pkg::ST_IDLE;
    end else begin
      case (state_r)
        tcpwm_pkg::ST_IDLE: begin
          if (start_rise) begin
            state_r <= tcpwm_pkg::ST_RUN;
          end
        end
        tcpwm_pkg::ST_RUN: begin
          if (!start_i) begin
            state_r <= tcpwm_pkg::ST_IDLE;
          end else if (advance && at_zero && mode_i == tcpwm_pkg::MODE_ONESHOT) begin
            state_r <= tcpwm_pkg::ST_IDLE;
          end
        end
        default: state_r <= tcpwm_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // counter
  // ----------------------------------------
  // period reload sources
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      count_r <= tcpwm_pkg::CNT_RST;
    end else if (start_rise || timer_reset_i) begin
      count_r <= period_i;
    end else if (advance && at_zero) begin
      count_r <= period_i;
    end else if (advance) begin
      count_r <= count_r - tcpwm_pkg::CNT_ONE;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tc_r <= 1'b0;
    end else begin
      tc_r <= advance && at_zero && !timer_reset_i && !start_rise;
    end
  end

  // ----------------------------------------
  // capture
  // ----------------------------------------
  assign cap_rise = capture_i && !cap_d_r;

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cap_d_r <= 1'b0;
    end else begin
      cap_d_r <= capture_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      capture_r <= tcpwm_pkg::CNT_RST;
    end else if (cap_rise) begin
      capture_r <= count_r;
    end
  end

  // ----------------------------------------
  // compare and interrupt
  // ----------------------------------------
  // selectable relation
  assign cmp_now = cmp_true(cmp_rel_i, count_r, compare_i);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmp_d_r <= 1'b0;
    end else begin
      cmp_d_r <= cmp_now;
    end
  end

  // selectable sources
  // event pulses, not sticky: the interrupt controller outside latches them
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= (irq_sel_i[tcpwm_pkg::IRQ_TC_BIT] && advance && at_zero) ||
               (irq_sel_i[tcpwm_pkg::IRQ_CMP_BIT] && cmp_now && !cmp_d_r) ||
               (irq_sel_i[tcpwm_pkg::IRQ_CAP_BIT] && cap_rise);
    end
  end

  // ----------------------------------------
  // deadband stage
  // ----------------------------------------
  assign pw.tick = tick;
  assign pw.raw = cmp_now;
  assign pw.kill = kill_i;
  assign pw.dead_len = dead_len_i;

  deadband_gen u_dead (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .pw(pw)
  );

  assign count_o = count_r;
  assign capture_o = capture_r;
  assign running_o = state_r == tcpwm_pkg::ST_RUN;
  assign compare_o = pw.pos;
  assign compare_n_o = pw.neg;
  assign tc_o = tc_r;
  assign irq_o = irq_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_wrap;
    advance && at_zero && !timer_reset_i && !start_rise;
  endsequence

  sequence s_step;
    advance && !at_zero && !timer_reset_i && !start_rise;
  endsequence

  a_count_steps_down: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_step |=> count_r == $past(count_r) - tcpwm_pkg::CNT_ONE)
    else $error("counter did not step down by one");

  a_wrap_reloads: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    s_wrap |=> (count_r == $past(period_i) && tc_r)) else $error("no reload at zero");

  a_tc_one_cycle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    tc_r |-> $past(advance) && $past(at_zero)) else $error("terminal count without wrap");

  a_oneshot_halts: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (s_wrap and (mode_i == tcpwm_pkg::MODE_ONESHOT)) |=> !running_o)
    else $error("one-shot kept running");

  a_gated_holds: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (mode_i == tcpwm_pkg::MODE_GATED && !enable_i && !timer_reset_i && !start_rise)
    |=> $stable(count_r)) else $error("gated counter moved without enable");

  a_capture_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    cap_rise |=> capture_r == $past(count_r)) else $error("capture missed counter value");

  a_irq_on_tc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (advance && at_zero && irq_sel_i[tcpwm_pkg::IRQ_TC_BIT]) |=> irq_o)
    else $error("no interrupt at terminal count");

  a_start_loads: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    start_rise |=> (count_r == $past(period_i) && running_o)) else $error("start did not load");

  a_kill_quiets: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    kill_i [*2] |-> (!compare_o && !compare_n_o)) else $error("outputs active under kill");
endmodule // timer_counter_pwm_16bit
`default_nettype wire

// >>> rtl/tcpwm_pkg.sv
// constants and types for the 16-bit timer, counter and pwm unit
// assumes a single 100 MHz system clock and a synchronous active-high reset
package tcpwm_pkg;
  localparam int CNT_W = 16;
  localparam int DB_W = 8;
  localparam int SRC_N = 3;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
  localparam logic [DB_W-1:0] DB_ZERO = 8'h00;
  localparam logic [DB_W-1:0] DB_ONE = 8'h01;
  localparam logic [SRC_N-1:0] SRC_RST = 3'h0;

  // compare relations between counter and compare value
  typedef enum logic [2:0] {
    less_than = 3'h0,
    less_or_equal = 3'h1,
    same_value = 3'h2,
    greater_or_equal = 3'h3,
    greater_than = 3'h4
  } cmp_rel_t;

  // counting modes
  typedef enum logic [1:0] {
    MODE_FREE = 2'h0,
    MODE_ONESHOT = 2'h1,
    MODE_GATED = 2'h2
  } run_mode_t;

  // counting clock selection: system clock or one of three synchronised sources
  localparam logic [1:0] CLKSEL_SYS = 2'h0;

  // interrupt source select bit positions
  localparam int IRQ_TC_BIT = 0;
  localparam int IRQ_CMP_BIT = 1;
  localparam int IRQ_CAP_BIT = 2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;
endpackage

// >>> rtl/pwm_if.sv
// carrier between the counter core and the deadband stage
// assumes both ends sit on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface pwm_if;
  logic tick;
  logic raw;
  logic kill;
  logic [tcpwm_pkg::DB_W-1:0] dead_len;
  logic pos;
  logic neg;
  modport ctrl (output tick, output raw, output kill, output dead_len, input pos, input neg);
  modport dead (input tick, input raw, input kill, input dead_len, output pos, output neg);
endinterface
`default_nettype wire

// >>> rtl/deadband_gen.sv
// complementary pwm pair with deadband and kill
// assumes tick is a one-cycle counting-clock enable on the system clock
`timescale 1ns/1ps
`default_nettype none
module deadband_gen (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  pwm_if.dead pw
);
  logic raw_d_r;
  logic [tcpwm_pkg::DB_W-1:0] gap_r;
  logic pos_r;
  logic neg_r;

  assign pw.pos = pos_r;
  assign pw.neg = neg_r;

  // ----------------------------------------
  // edge tracking and gap counter
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      raw_d_r <= 1'b0;
    end else begin
      raw_d_r <= pw.raw;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      gap_r <= tcpwm_pkg::DB_ZERO;
    end else if (pw.raw != raw_d_r) begin
      gap_r <= pw.dead_len;
    end else if (pw.tick && gap_r != tcpwm_pkg::DB_ZERO) begin
      gap_r <= gap_r - tcpwm_pkg::DB_ONE;
    end
  end

  // ----------------------------------------
  // output pair
  // ----------------------------------------
  // both low during gap
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pos_r <= 1'b0;
      neg_r <= 1'b0;
    end else if (pw.kill) begin
      pos_r <= 1'b0;
      neg_r <= 1'b0;
    end else if (pw.raw != raw_d_r && pw.dead_len != tcpwm_pkg::DB_ZERO) begin
      pos_r <= 1'b0;
      neg_r <= 1'b0;
    end else if (pw.raw != raw_d_r) begin
      pos_r <= pw.raw;
      neg_r <= !pw.raw;
    end else if (gap_r != tcpwm_pkg::DB_ZERO) begin
      pos_r <= 1'b0;
      neg_r <= 1'b0;
    end else begin
      pos_r <= pw.raw;
      neg_r <= !pw.raw;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_pair_never_both: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(pos_r && neg_r)) else $error("complementary outputs both active");

  a_kill_forces_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    pw.kill |=> (!pos_r && !neg_r)) else $error("kill did not force outputs low");

  a_gap_holds_low: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (pw.raw != raw_d_r && pw.dead_len != tcpwm_pkg::DB_ZERO) |=> (!pos_r && !neg_r))
    else $error("deadband gap not inserted");
endmodule // deadband_gen
`default_nettype wire

// >>> tb/src_model.sv
// fabric-side model: three foreign counting clock sources
// assumes the bench runs them only between start and stop of a count run
`timescale 1ns/1ps
`default_nettype none
module src_model (
  input wire logic run_i,
  output var logic [2:0] src_o
);
  // unrelated half periods, slow enough for a two-stage synchroniser
  initial src_o = 3'h0;
  // sources stand still outside a run
  always #47 if (run_i) src_o[0] = ~src_o[0];
  always #53 if (run_i) src_o[1] = ~src_o[1];
  always #71 if (run_i) src_o[2] = ~src_o[2];
endmodule // src_model
`default_nettype wire

// >>> tb/tb.sv
// self-checking bench for the 16-bit timer, counter and pwm unit
// assumes all dut inputs except the foreign clk_src_i change at the falling edge of ref_clk_i
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [2:0] rel; logic [15:0] cmp; logic exp;} row_t;
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] clk_sel_i = 2'h0;
  logic start_i = 1'b0;
  logic [1:0] mode_i = 2'h0;
  logic [2:0] cmp_rel_i = 3'h5;
  logic [15:0] period_i = 16'h0002;
  logic [15:0] compare_i = 16'h0000;
  logic [7:0] dead_len_i = 8'h00;
  logic [2:0] irq_sel_i = 3'h1;
  logic enable_i = 1'b0;
  logic timer_reset_i = 1'b0;
  logic capture_i = 1'b0;
  logic kill_i = 1'b0;
  logic run_src = 1'b0;
  logic [2:0] clk_src;
  logic [15:0] count_o, capture_o;
  logic running_o, compare_o, compare_n_o, tc_o, irq_o;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int tc_cnt = 0;
  int irq_cnt = 0;
  int both_cnt = 0;
  int rises[3] = '{0, 0, 0};
  int a;
  logic [15:0] walk_exp[5] = '{16'h0002, 16'h0001, 16'h0000, 16'h0002, 16'h0001};
  logic [15:0] one_exp[6] = '{16'h0002, 16'h0001, 16'h0000, 16'h0002, 16'h0002, 16'h0002};
  // count is 0 and idle when the table runs
  row_t rows[11] = '{'{3'h0, 16'h0001, 1'b1}, '{3'h0, 16'h0000, 1'b0},
    '{3'h1, 16'h0000, 1'b1}, '{3'h1, 16'h0001, 1'b1}, '{3'h2, 16'h0000, 1'b1},
    '{3'h2, 16'h0001, 1'b0}, '{3'h3, 16'h0000, 1'b1}, '{3'h3, 16'h0001, 1'b0},
    '{3'h4, 16'h0000, 1'b0}, '{3'h4, 16'h0001, 1'b0}, '{3'h5, 16'h0000, 1'b0}};

  always #5 ref_clk_i = ~ref_clk_i;

  src_model partner (.run_i(run_src), .src_o(clk_src));

  timer_counter_pwm_16bit dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .clk_sel_i(clk_sel_i),
    .clk_src_i(clk_src), .start_i(start_i), .mode_i(mode_i), .cmp_rel_i(cmp_rel_i),
    .period_i(period_i), .compare_i(compare_i), .dead_len_i(dead_len_i),
    .irq_sel_i(irq_sel_i), .enable_i(enable_i), .timer_reset_i(timer_reset_i),
    .capture_i(capture_i), .kill_i(kill_i), .count_o(count_o), .capture_o(capture_o),
    .running_o(running_o), .compare_o(compare_o), .compare_n_o(compare_n_o),
    .tc_o(tc_o), .irq_o(irq_o));

  // pulse counters; a stuck pulse shows as extra counts
  always @(posedge ref_clk_i) begin
    cycles++;
    tc_cnt += (tc_o === 1'b1);
    irq_cnt += (irq_o === 1'b1);
    both_cnt += (compare_o === 1'b1 && compare_n_o === 1'b1);
    if (cycles == 5000) begin
      miscompares++;
      give_verdict();
    end
  end
  always @(posedge clk_src[0]) rises[0]++;
  always @(posedge clk_src[1]) rises[1]++;
  always @(posedge clk_src[2]) rises[2]++;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask

  // returns at the falling edge after the start rise was taken
  task automatic start_run(input logic [1:0] m, input logic [15:0] p);
    @(negedge ref_clk_i);
    start_i = 1'b0;
    mode_i = m;
    period_i = p;
    @(negedge ref_clk_i);
    start_i = 1'b1;
    @(negedge ref_clk_i);
  endtask

  task automatic reset_dut();
    @(negedge ref_clk_i);
    rst_i = 1'b1;
    cyc(4);
    check("count rst", count_o, 16'h0000);
    check("running rst", 16'(running_o), 16'h0000);
    check("tc rst", 16'(tc_o), 16'h0000);
    check("capture rst", capture_o, 16'h0000);
    check("irq rst", 16'(irq_o), 16'h0000);
    check("pair rst", 16'({compare_o, compare_n_o}), 16'h0000);
    rst_i = 1'b0;
    start_i = 1'b0;
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    reset_dut();
    // relation table, counter idle at zero
    foreach (rows[i]) begin
      cmp_rel_i = rows[i].rel;
      compare_i = rows[i].cmp;
      cyc(4);
      check("compare", 16'(compare_o), 16'(rows[i].exp));
      check("compare_n", 16'(compare_n_o), 16'(!rows[i].exp));
    end
    // ---------------------------------------------------------------
    // kill and deadband
    // ---------------------------------------------------------------
    cmp_rel_i = 3'h1;
    cyc(4);
    kill_i = 1'b1;
    cyc(2);
    check("kill pair", 16'({compare_o, compare_n_o}), 16'h0000);
    kill_i = 1'b0;
    cyc(3);
    check("after kill", 16'(compare_o), 16'h0001);
    dead_len_i = 8'h04;
    compare_i = 16'h0001;
    cmp_rel_i = 3'h2;
    cyc(2);
    check("gap low", 16'({compare_o, compare_n_o}), 16'h0000);
    cyc(8);
    check("neg after gap", 16'(compare_n_o), 16'h0001);
    compare_i = 16'h0000;
    cyc(2);
    check("gap low 2", 16'({compare_o, compare_n_o}), 16'h0000);
    cyc(8);
    check("pos after gap", 16'(compare_o), 16'h0001);
    cmp_rel_i = 3'h5;
    dead_len_i = 8'h00;
    // walk of a free run with reload and terminal count
    start_run(2'h0, 16'h0002);
    for (int k = 0; k < 5; k++) begin
      check("walk count", count_o, walk_exp[k]);
      check("walk tc", 16'(tc_o), 16'(k == 3));
      check("walk irq", 16'(irq_o), 16'(k == 3));
      cyc(1);
    end
    a = tc_cnt;
    cyc(39);
    check("free tc", 16'(tc_cnt - a), 16'h000d);
    start_run(2'h1, 16'h0002);
    for (int k = 0; k < 6; k++) begin
      check("one count", count_o, one_exp[k]);
      check("one run", 16'(running_o), 16'(k < 3));
      cyc(1);
    end
    start_run(2'h2, 16'h0005);
    cyc(3);
    check("gate hold", count_o, 16'h0005);
    enable_i = 1'b1;
    cyc(1);
    enable_i = 1'b0;
    cyc(3);
    check("gate step", count_o, 16'h0004);
    // reset input raised at zero: reload wins, no terminal count
    start_run(2'h0, 16'h0002);
    cyc(2);
    timer_reset_i = 1'b1;
    a = tc_cnt;
    cyc(3);
    check("treset", count_o, 16'h0002);
    timer_reset_i = 1'b0;
    cyc(1);
    check("treset go", count_o, 16'h0001);
    check("treset tc", 16'(tc_cnt - a), 16'h0000);
    irq_sel_i = 3'h4;
    start_run(2'h0, 16'h0100);
    cyc(2);
    a = irq_cnt;
    capture_i = 1'b1;
    cyc(1);
    check("capture", capture_o, 16'h00fe);
    cyc(3);
    capture_i = 1'b0;
    cyc(2);
    check("cap irq", 16'(irq_cnt - a), 16'h0001);
    reset_dut();
    // compare becoming true gives one interrupt pulse
    irq_sel_i = 3'h2;
    a = irq_cnt;
    cmp_rel_i = 3'h2;
    cyc(4);
    check("cmp irq", 16'(irq_cnt - a), 16'h0001);
    cmp_rel_i = 3'h5;
    irq_sel_i = 3'h1;
    // foreign clock sources; long runs keep the three rise counts apart
    for (int s = 1; s < 4; s++) begin
      clk_sel_i = 2'(s);
      start_run(2'h0, 16'h0100);
      a = rises[s - 1];
      run_src = 1'b1;
      cyc(200);
      run_src = 1'b0;
      cyc(8);
      check("ext count", count_o, 16'h0100 - 16'(rises[s - 1] - a));
    end
    check("overlap", 16'(both_cnt), 16'h0000);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
